// ===== rtl/compare_and_pwm_unit.sv
// Purpose: compare and pwm unit with its timers and register file
// Assumes: inputs synchronous to clk_sys; Avalon-MM slave, 32-bit data, low byte used
// Notes: capture modes are accepted but do nothing
`timescale 1ns/1ps
`default_nettype none
module compare_and_pwm_unit #(
  parameter bit SECOND_UNIT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic adc_enable,
  output logic adc_start,
  output logic unit_pin_out,
  output logic unit_pin_oe_n
);
  import ccp_unit_pkg::*;

  typedef struct packed {
    logic [7:0] interrupt_control;
    logic [7:0] peripheral_flags_one;
    logic [7:0] peripheral_enables_one;
    logic [7:0] timer1_setup;
    logic [7:0] timer2_setup;
    logic [7:0] port_c_direction;
    logic [7:0] pr2;
    logic [7:0] timer2_counter;
    logic [15:0] timer1_count;
    logic [7:0] ccpr_l;
    logic [7:0] ccpr_h;
    logic [7:0] ctrl;
    logic [1:0] low2;
    logic [1:0] q;
    logic [2:0] t1_pre;
    logic [3:0] t2_pre;
    logic [3:0] t2_post;
    logic t1_eq;
    logic pin;
    logic adc_start;
    logic waitrequest;
    logic [7:0] rdata;
  } state_s;

  state_s s;
  state_s next_s;
  logic acc_wr;
  logic cmp_hit;
  logic t2_roll;
  logic duty_eq;
  logic pwm;
  logic [3:0] mode;

  // byte address of a register index
  function automatic logic reg_at(input logic [9:0] a, input logic [7:0] idx);
    reg_at = (a == {idx, 2'b00});
  endfunction

  // last prescaler count for the timer2 prescale select
  function automatic logic [3:0] t2_pre_last(input logic [1:0] ps);
    t2_pre_last = ps[1] ? 4'hf : (ps[0] ? 4'h3 : 4'h0);
  endfunction

  // next state
  always_comb begin
    logic [7:0] wd;
    logic tick;
    logic set_ev;
    logic set_t1ov;
    logic set_t2;
    logic [1:0] lowb;
    wd = writedata[7:0];
    tick = 1'b0;
    set_ev = 1'b0;
    set_t1ov = 1'b0;
    set_t2 = 1'b0;
    lowb = 2'b00;
    next_s = s;
    mode = s.ctrl[3:0];
    pwm = (mode[3:2] == MODE_PWM_TOP);
    acc_wr = write && !s.waitrequest;
    t2_roll = 1'b0;
    next_s.adc_start = 1'b0;

    // bus handshake: one wait cycle, then one answer cycle
    next_s.waitrequest = !((read || write) && s.waitrequest);

    // quarter-step counter: timers advance once per four clocks
    next_s.q = s.q + 2'd1;
    tick = (s.q == Q_LAST);

    // timer1 with its prescaler
    if (s.timer1_setup[BIT_TIMER1_ON] && tick) begin
      if (s.t1_pre == 3'((4'd1 << s.timer1_setup[5:4]) - 4'd1)) begin
        next_s.t1_pre = 3'd0;
        next_s.timer1_count = s.timer1_count + 16'h0001;
        set_t1ov = (s.timer1_count == 16'hffff);
      end else begin
        next_s.t1_pre = s.t1_pre + 3'd1;
      end
    end

    // timer2, prescaler 1/4/16, wrap after the period match
    if (s.timer2_setup[BIT_TIMER2_ON] && tick) begin
      if (s.t2_pre == t2_pre_last(s.timer2_setup[1:0])) begin
        next_s.t2_pre = 4'h0;
        if (s.timer2_counter == s.pr2) begin
          t2_roll = 1'b1;
          next_s.timer2_counter = RST_ZERO;
          // postscaler gates only the timer2 flag
          if (s.t2_post == s.timer2_setup[6:3]) begin
            next_s.t2_post = 4'h0;
            set_t2 = 1'b1;
          end else begin
            next_s.t2_post = s.t2_post + 4'h1;
          end
        end else begin
          next_s.timer2_counter = s.timer2_counter + 8'h01;
        end
      end else begin
        next_s.t2_pre = s.t2_pre + 4'h1;
      end
    end

    // compare: one hit per arrival at equality
    next_s.t1_eq = (s.timer1_count == {s.ccpr_h, s.ccpr_l});
    cmp_hit = (mode[3:2] == MODE_CMP_TOP) && next_s.t1_eq && !s.t1_eq;
    if (cmp_hit) begin
      set_ev = 1'b1;
      case (mode)
        MODE_SET: next_s.pin = 1'b1;
        MODE_CLEAR: next_s.pin = 1'b0;
        MODE_FLAG: next_s.pin = s.pin;
        MODE_TRIG: begin
          next_s.timer1_count = 16'h0000;
          next_s.t1_pre = 3'd0;
          set_t1ov = 1'b0;
          next_s.adc_start = SECOND_UNIT && adc_enable;
        end
        default: next_s.pin = s.pin;
      endcase
    end

    // pwm: low bits from quarter clock or timer2 prescaler, as they stand after this edge
    case (s.timer2_setup[1:0])
      2'b00: lowb = next_s.q;
      2'b01: lowb = next_s.t2_pre[1:0];
      default: lowb = next_s.t2_pre[3:2];
    endcase
    // match on the coming count so the high time is exactly duty steps, not one clock more
    duty_eq = ({s.ccpr_h, s.low2} == {next_s.timer2_counter, lowb});
    if (pwm) begin
      if (t2_roll) begin
        next_s.pin = ({s.ccpr_l, s.ctrl[5:4]} != 10'h000);
        next_s.ccpr_h = s.ccpr_l;
        next_s.low2 = s.ctrl[5:4];
      end else if (duty_eq) begin
        // a duty past the period never gets here
        next_s.pin = 1'b0;
      end
    end

    // register writes
    if (acc_wr) begin
      if (reg_at(address, IDX_INTERRUPT_CONTROL)) next_s.interrupt_control = wd;
      if (reg_at(address, IDX_PERIPHERAL_FLAGS_ONE)) next_s.peripheral_flags_one = wd;
      if (reg_at(address, IDX_PERIPHERAL_ENABLES_ONE)) next_s.peripheral_enables_one = wd;
      if (reg_at(address, IDX_TIMER1_COUNT_LOW)) next_s.timer1_count[7:0] = wd;
      if (reg_at(address, IDX_TIMER1_COUNT_HIGH)) next_s.timer1_count[15:8] = wd;
      if (reg_at(address, IDX_TIMER1_SETUP)) next_s.timer1_setup = {2'b00, wd[5:0]};
      if (reg_at(address, IDX_PORT_C_DIRECTION)) next_s.port_c_direction = wd;
      if (reg_at(address, IDX_TIMER2_PERIOD)) next_s.pr2 = wd;
      if (reg_at(address, IDX_MATCH_VALUE_LOW)) next_s.ccpr_l = wd;
      // active duty is read-only while in pwm
      if (reg_at(address, IDX_MATCH_VALUE_HIGH) && !pwm) next_s.ccpr_h = wd;
      if (reg_at(address, IDX_TIMER2_COUNTER)) begin
        next_s.timer2_counter = wd;
        next_s.t2_pre = 4'h0;
        next_s.t2_post = 4'h0;
      end
      if (reg_at(address, IDX_TIMER2_SETUP)) begin
        next_s.timer2_setup = {1'b0, wd[6:0]};
        next_s.t2_pre = 4'h0;
        next_s.t2_post = 4'h0;
      end
      if (reg_at(address, IDX_UNIT_CONTROL)) next_s.ctrl = {2'b00, wd[5:0]};
    end

    // unit off holds the output latch low; port data is not touched
    if (next_s.ctrl[3:0] == MODE_OFF) begin
      next_s.pin = 1'b0;
      next_s.t1_eq = 1'b0;
    end

    // flag sets win over a software write in the same cycle
    next_s.peripheral_flags_one[BIT_UNIT_EVENT] = next_s.peripheral_flags_one[BIT_UNIT_EVENT] | set_ev;
    next_s.peripheral_flags_one[BIT_TIMER1_OVF] = next_s.peripheral_flags_one[BIT_TIMER1_OVF] | set_t1ov;
    next_s.peripheral_flags_one[BIT_TIMER2_FLAG] = next_s.peripheral_flags_one[BIT_TIMER2_FLAG] | set_t2;

    // read data captured on the request's first cycle
    if (read && s.waitrequest) begin
      next_s.rdata = RST_ZERO;
      if (reg_at(address, IDX_INTERRUPT_CONTROL)) next_s.rdata = s.interrupt_control;
      if (reg_at(address, IDX_PERIPHERAL_FLAGS_ONE)) next_s.rdata = s.peripheral_flags_one;
      if (reg_at(address, IDX_PERIPHERAL_ENABLES_ONE)) next_s.rdata = s.peripheral_enables_one;
      if (reg_at(address, IDX_TIMER1_COUNT_LOW)) next_s.rdata = s.timer1_count[7:0];
      if (reg_at(address, IDX_TIMER1_COUNT_HIGH)) next_s.rdata = s.timer1_count[15:8];
      if (reg_at(address, IDX_TIMER1_SETUP)) next_s.rdata = s.timer1_setup;
      if (reg_at(address, IDX_TIMER2_COUNTER)) next_s.rdata = s.timer2_counter;
      if (reg_at(address, IDX_TIMER2_SETUP)) next_s.rdata = s.timer2_setup;
      if (reg_at(address, IDX_MATCH_VALUE_LOW)) next_s.rdata = s.ccpr_l;
      if (reg_at(address, IDX_MATCH_VALUE_HIGH)) next_s.rdata = s.ccpr_h;
      if (reg_at(address, IDX_UNIT_CONTROL)) next_s.rdata = s.ctrl;
      if (reg_at(address, IDX_PORT_C_DIRECTION)) next_s.rdata = s.port_c_direction;
      if (reg_at(address, IDX_TIMER2_PERIOD)) next_s.rdata = s.pr2;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.port_c_direction <= RST_DIRECTION;
      s.pr2 <= RST_PERIOD;
      s.waitrequest <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops; pin driven while direction bit is low
  assign readdata = {24'h00_0000, s.rdata};
  assign waitrequest = s.waitrequest;
  assign adc_start = s.adc_start;
  assign unit_pin_out = s.pin;
  assign unit_pin_oe_n = s.port_c_direction[BIT_UNIT_PIN];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // compare and pwm actions
  chk_set_on_match: assert property (
    cmp_hit && mode == MODE_SET && !acc_wr |=> s.pin)
    else $error("pin not set on compare match");
  chk_flag_on_match: assert property (
    cmp_hit |=> s.peripheral_flags_one[BIT_UNIT_EVENT])
    else $error("event flag not set on match");
  chk_zero_ctrl_low: assert property (
    acc_wr && reg_at(address, IDX_UNIT_CONTROL) && writedata[7:0] == 8'h00
    |=> !s.pin ##1 !s.pin)
    else $error("output latch not forced low");
  chk_flag_only_pin: assert property (
    cmp_hit && mode == MODE_FLAG && !acc_wr |=> $stable(s.pin))
    else $error("pin moved in flag-only mode");
  chk_trig_reset: assert property (
    cmp_hit && mode == MODE_TRIG && !acc_wr |=> s.timer1_count == 16'h0000)
    else $error("timer1 not reset by trigger");
  chk_adc_pulse: assert property (
    cmp_hit && mode == MODE_TRIG && SECOND_UNIT && adc_enable
    |=> s.adc_start ##1 !s.adc_start)
    else $error("a/d start pulse wrong");
  chk_trig_no_ovf: assert property (
    cmp_hit && mode == MODE_TRIG && !acc_wr
    |=> s.peripheral_flags_one[BIT_TIMER1_OVF] == $past(s.peripheral_flags_one[BIT_TIMER1_OVF]))
    else $error("trigger set overflow flag");
  chk_duty_latch: assert property (
    pwm && t2_roll && !acc_wr
    |=> s.ccpr_h == $past(s.ccpr_l) && s.low2 == $past(s.ctrl[5:4]) && s.timer2_counter == 8'h00)
    else $error("duty not latched at period end");
  chk_duty_clear: assert property (
    pwm && duty_eq && !t2_roll && !acc_wr |=> !s.pin)
    else $error("pin not cleared at duty match");
endmodule
`default_nettype wire

// ===== rtl/ccp_unit_pkg.sv
// Purpose: constants shared by the compare and pwm unit
// Assumes: 40 MHz system clock, Avalon-MM byte addresses
// Notes: register byte address is four times its index
package ccp_unit_pkg;
  // timing: one timer step is four oscillator periods
  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_PERIOD_NS = 25;
  localparam int STEP_NS = 4 * OSC_PERIOD_NS;
  localparam int STEP_CYCLES = STEP_NS / CLK_PERIOD_NS;
  localparam logic [1:0] Q_LAST = 2'(STEP_CYCLES - 1);
  // register indexes
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS_ONE = 8'h0c;
  localparam logic [7:0] IDX_TIMER1_COUNT_LOW = 8'h0e;
  localparam logic [7:0] IDX_TIMER1_COUNT_HIGH = 8'h0f;
  localparam logic [7:0] IDX_TIMER1_SETUP = 8'h10;
  localparam logic [7:0] IDX_TIMER2_COUNTER = 8'h11;
  localparam logic [7:0] IDX_TIMER2_SETUP = 8'h12;
  localparam logic [7:0] IDX_MATCH_VALUE_LOW = 8'h15;
  localparam logic [7:0] IDX_MATCH_VALUE_HIGH = 8'h16;
  localparam logic [7:0] IDX_UNIT_CONTROL = 8'h17;
  localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h87;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES_ONE = 8'h8c;
  localparam logic [7:0] IDX_TIMER2_PERIOD = 8'h92;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hff;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  // field positions
  localparam int BIT_TIMER1_OVF = 0;
  localparam int BIT_TIMER2_FLAG = 1;
  localparam int BIT_UNIT_EVENT = 2;
  localparam int BIT_TIMER1_ON = 0;
  localparam int BIT_TIMER2_ON = 2;
  localparam int BIT_UNIT_PIN = 2;
  // mode select encodings
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLEAR = 4'h9;
  localparam logic [3:0] MODE_FLAG = 4'ha;
  localparam logic [3:0] MODE_TRIG = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  localparam logic [1:0] MODE_CMP_TOP = 2'h2;
endpackage

// ===== dv/compare_and_pwm_unit_tb_top.sv
// Purpose: self-checking bench for the compare and pwm unit
// Assumes: second unit build, timer1 at prescale 1, pwm period 7
// Notes: reads are scored from a queue by a monitor process
`timescale 1ns/1ps
`default_nettype none
module compare_and_pwm_unit_tb_top;
  import ccp_unit_pkg::*;
  logic clk_sys = 0;
  logic resetn = 0;
  logic read = 0;
  logic write = 0;
  logic adc_enable = 1;
  logic [9:0] address = '0;
  logic [31:0] writedata = '0;
  logic [31:0] readdata;
  logic waitrequest, adc_start, unit_pin_out, unit_pin_oe_n;
  logic [7:0] exp_q[$];
  logic [7:0] m;
  logic [9:0] duty;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 41;
  int n, hi, per;
  logic [3:0] modes[4] = '{MODE_SET, MODE_FLAG, MODE_CLEAR, MODE_SET};
  logic pins[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic [7:0] setups[4] = '{8'h04, 8'h05, 8'h06, 8'h7c};
  int facts[4] = '{1, 4, 16, 1};
  compare_and_pwm_unit #(.SECOND_UNIT(1'b1)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .adc_enable(adc_enable),
    .adc_start(adc_start), .unit_pin_out(unit_pin_out), .unit_pin_oe_n(unit_pin_oe_n));
  // clock and hang guard
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      give_verdict();
    end
  end
  // score each read against the oldest note
  always @(posedge clk_sys) begin
    if (read && waitrequest === 1'b0) begin
      chk("readdata", {8'h00, exp_q.pop_front()}, {8'h00, readdata[7:0]});
    end
  end
  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(logic [7:0] idx, logic wr_en, logic [7:0] d);
    @(posedge clk_sys);
    address <= {idx, 2'b00};
    write <= wr_en;
    read <= ~wr_en;
    writedata <= {24'h0000, d};
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(logic [7:0] idx, logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask
  task automatic rd(logic [7:0] idx, logic [7:0] e);
    exp_q.push_back(e);
    bus(idx, 1'b0, 8'h00);
  endtask
  task automatic wait_pin(logic v);
    n = 0;
    while (unit_pin_out !== v && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic wait_adc();
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (adc_start !== 1'b1 && n < 1000);
  endtask
  // high time and rise-to-rise time of one pwm pulse
  task automatic pulse();
    wait_pin(1'b0);
    wait_pin(1'b1);
    hi = 0;
    while (unit_pin_out === 1'b1 && hi < 600) begin
      @(posedge clk_sys);
      hi++;
    end
    wait_pin(1'b1);
    per = hi + n;
  endtask
  // cycles over 96 where the pin differs from v, after a settling gap
  task automatic hold(logic v);
    repeat (64) @(posedge clk_sys);
    n = 0;
    repeat (96) begin
      @(posedge clk_sys);
      if (unit_pin_out !== v) n++;
    end
  endtask
  // rerun timer1 from zero toward match m in mode md
  task automatic cmp(logic [3:0] md);
    wr(IDX_TIMER1_SETUP, 8'h00);
    wr(IDX_TIMER1_COUNT_LOW, 8'h00);
    wr(IDX_TIMER1_COUNT_HIGH, 8'h00);
    wr(IDX_MATCH_VALUE_LOW, m);
    wr(IDX_MATCH_VALUE_HIGH, 8'h00);
    wr(IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
    wr(IDX_UNIT_CONTROL, {4'h0, md});
    wr(IDX_TIMER1_SETUP, 8'h01);
    repeat (4 * m + 16) @(posedge clk_sys);
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(IDX_TIMER2_PERIOD, RST_PERIOD);
    rd(IDX_PORT_C_DIRECTION, RST_DIRECTION);
    rd(IDX_UNIT_CONTROL, RST_ZERO);
    rd(IDX_PERIPHERAL_FLAGS_ONE, RST_ZERO);
    rd(8'h3f, RST_ZERO);
    chk("oe_n", 16'h0001, {15'h0000, unit_pin_oe_n});
    wr(IDX_PORT_C_DIRECTION, 8'hfb);
    repeat (2) @(posedge clk_sys);
    chk("oe_n", 16'h0000, {15'h0000, unit_pin_oe_n});
    m = 8'h08 + 8'($unsigned($random(seed)) % 32);
    for (int i = 0; i < 4; i++) begin
      cmp(modes[i]);
      chk("pin", {15'h0000, pins[i]}, {15'h0000, unit_pin_out});
      rd(IDX_PERIPHERAL_FLAGS_ONE, 8'h04);
    end
    wr(IDX_UNIT_CONTROL, {4'h0, MODE_OFF});
    repeat (2) @(posedge clk_sys);
    chk("pin", 16'h0000, {15'h0000, unit_pin_out});
    cmp(MODE_TRIG);
    wait_adc();
    wait_adc();
    chk("trig_period", 16'h0001, 16'(n >= 4 * m && n <= 4 * m + 4));
    rd(IDX_PERIPHERAL_FLAGS_ONE, 8'h04);
    adc_enable <= 1'b0;
    wait_adc();
    chk("no_start", 16'h0001, 16'(n >= 1000));
    wr(IDX_TIMER2_PERIOD, 8'h07);
    for (int i = 0; i < 4; i++) begin
      duty = 10'(1 + ($unsigned($random(seed)) % 31));
      wr(IDX_MATCH_VALUE_LOW, duty[9:2]);
      wr(IDX_TIMER2_SETUP, setups[i]);
      wr(IDX_UNIT_CONTROL, {2'b00, duty[1:0], 4'hc});
      pulse();
      pulse();
      chk("high_time", 16'(duty * facts[i]), 16'(hi));
      chk("period", 16'(32 * facts[i]), 16'(per));
    end
    wr(IDX_MATCH_VALUE_HIGH, 8'h00);
    rd(IDX_MATCH_VALUE_HIGH, duty[9:2]);
    wr(IDX_TIMER2_SETUP, 8'h04);
    wr(IDX_MATCH_VALUE_LOW, 8'hff);
    wr(IDX_UNIT_CONTROL, 8'h3c);
    hold(1'b1);
    chk("low_cycles", 16'h0000, 16'(n));
    wr(IDX_MATCH_VALUE_LOW, 8'h00);
    wr(IDX_UNIT_CONTROL, 8'h0c);
    hold(1'b0);
    chk("high_cycles", 16'h0000, 16'(n));
    give_verdict();
  end
endmodule
`default_nettype wire
